// >>> verilog/afb_pkg.sv
// Purpose: Constants and types for the parallel FIFO / bit-bang port.
// Assumes: 100 MHz clk_sys, synchronous active-high reset.
// Notes:   Register offsets are byte addresses on a 32-bit Avalon slave.
//
// Summary of operation
// R1: FIFO mode: data bus is input; driven only while read strobe is low.
// R2: Receive flag low when a byte waits; no read while it is high.
// R3: After read strobe rises, receive flag goes high; low again if more.
// R4: Transmit flag low when a byte fits; write by strobing high then low.
// R5: Read strobe falling edge puts current receive byte on the bus.
// R6: Read strobe rising edge advances the receive buffer to the next byte.
// R7: Write strobe falling edge captures the bus byte into transmit buffer.
// R8: During reset both flag outputs are undriven, pulled high outside.
// R9: Suspended and wake enabled: wake strobe low requests a bus resume.
// R10: Not suspended: wake strobe low flushes buffered transmit data.
// R11: FIFO mode is chosen only by the stored port-mode setting.
// R12: Bit-bang mode makes the eight lines a host-driven bidirectional bus.
// R13: Synchronous and asynchronous bit-bang share the same pins and strobes.
// R14: Bit-bang: write strobe output pulses low when new data is driven.
// R15: Bit-bang: read strobe output rises once the pins have been sampled.
// R16: Transmit flag high while transmit buffer is full, low once space.

package afb_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int       DW         = 8;
    localparam int       FIFO_DEPTH = 16;
    localparam int       CNT_W      = 5;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_ZERO = 5'h00;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [4:0] REG_CTRL    = 5'h00;
    localparam logic [4:0] REG_STAT    = 5'h04;
    localparam logic [4:0] REG_RX_PUSH = 5'h08;
    localparam logic [4:0] REG_TX_POP  = 5'h0C;
    localparam logic [4:0] REG_BB_OUT  = 5'h10;
    localparam logic [4:0] REG_BB_DIR  = 5'h14;
    localparam logic [4:0] REG_BB_IN   = 5'h18;

    // Control fields
    localparam int       CTRL_WAKE_EN = 2;
    localparam int       CTRL_SUSPEND = 3;
    localparam logic [7:0] CTRL_RST   = 8'h00;

    // Status fields
    localparam int       ST_RESUME = 0;
    localparam int       ST_FLUSH  = 1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_FIFO     = 2'b00,
        MODE_BB_ASYNC = 2'b01,
        MODE_BB_SYNC  = 2'b10,
        MODE_OFF      = 2'b11
    } afb_mode_t;

    typedef struct packed {
        logic [7:0] data;
        logic       rd_n;
        logic       wr_n;
        logic       wake_n;
    } afb_pin_in_t;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] data_oe;
        logic       rx_avail_n;
        logic       rx_avail_oe;
        logic       tx_space_n;
        logic       tx_space_oe;
        logic       power_enable_n;
        logic       pin_write_pulse_n;
        logic       pin_sample_pulse_n;
    } afb_pin_out_t;

    localparam afb_pin_out_t PIN_RST = '{
        data: 8'h00, data_oe: 8'h00,
        rx_avail_n: 1'b1, rx_avail_oe: 1'b0,
        tx_space_n: 1'b1, tx_space_oe: 1'b0,
        power_enable_n: 1'b1,
        pin_write_pulse_n: 1'b1, pin_sample_pulse_n: 1'b1
    };

endpackage

// >>> verilog/afb_port.sv
// Purpose: Parallel FIFO / bit-bang port of one channel, Avalon slave.
// Assumes: Pin inputs synchronous to clk_sys; one clock domain.
// Notes:   Software plays the USB side through the register map.
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps

// ****************************************************************
// Buffer
// ****************************************************************
module afb_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input  logic                   clk_sys,
    input  logic                   rst,
    // Fill side
    input  logic                   in_valid,
    output logic                   in_ready,
    input  logic [W-1:0]           in_data,
    // Drain side
    output logic                   out_valid,
    input  logic                   out_ready,
    output logic [W-1:0]           out_data,
    output logic [$clog2(D):0]     count
);
    localparam int PW = $clog2(D);
    localparam logic [PW:0] FULL = (PW+1)'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wp;
        logic [PW-1:0]       rp;
        logic [PW:0]         cnt;
    } afb_fifo_st_t;

    afb_fifo_st_t s_reg;
    afb_fifo_st_t s_next;
    logic         push;
    logic         pop;

    assign in_ready  = (s_reg.cnt != FULL);
    assign out_valid = (s_reg.cnt != '0);
    assign out_data  = s_reg.mem[s_reg.rp];
    assign count     = s_reg.cnt;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wp] = in_data;
            s_next.wp            = s_reg.wp + PW'(1);
        end
        if (pop) begin
            s_next.rp = s_reg.rp + PW'(1);
        end
        s_next.cnt = s_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // afb_fifo

// ****************************************************************
// Port
// ****************************************************************
module afb_port (
    // Clock and reset
    input  logic                 clk_sys,
    input  logic                 rst,
    // Avalon-MM slave
    input  logic [4:0]           avs_address,
    input  logic                 avs_read,
    input  logic                 avs_write,
    input  logic [3:0]           avs_byteenable,
    input  logic [31:0]          avs_writedata,
    output logic [31:0]          avs_readdata,
    output logic                 avs_waitrequest,
    // Parallel pins
    input  afb_pkg::afb_pin_in_t  pin_i,
    output afb_pkg::afb_pin_out_t pin_o
);
    typedef struct packed {
        afb_pkg::afb_pin_out_t pin;
        logic [31:0]           rdata;
        logic                  waitreq;
        logic [7:0]            ctrl;
        logic [7:0]            bb_out;
        logic [7:0]            bb_dir;
        logic [7:0]            bb_in;
        logic                  rd_n_q;
        logic                  wr_n_q;
        logic                  wake_n_q;
        logic                  resume_req;
        logic                  flush_req;
    } afb_port_st_t;

    localparam afb_port_st_t ST_RST = '{
        pin: afb_pkg::PIN_RST, waitreq: 1'b1,
        ctrl: afb_pkg::CTRL_RST,
        rd_n_q: 1'b1, wr_n_q: 1'b1, wake_n_q: 1'b1,
        default: '0
    };

    afb_port_st_t        s_reg;
    afb_port_st_t        s_next;
    afb_pkg::afb_mode_t  mode;
    logic                rd_fall;
    logic                rd_rise;
    logic                wr_fall;
    logic                wake_fall;
    logic                req;
    logic                commit;
    logic                stall;
    logic                rx_push;
    logic                rx_pop;
    logic                rx_ready;
    logic                rx_valid;
    logic [7:0]          rx_head;
    logic [4:0]          rx_cnt;
    logic [4:0]          rx_cnt_next;
    logic                tx_push;
    logic                tx_pop;
    logic                tx_ready;
    logic                tx_valid;
    logic [7:0]          tx_head;
    logic [4:0]          tx_cnt;
    logic [4:0]          tx_cnt_next;
    logic [31:0]         rd_mux;

    // ************************************************************
    // Buffers: bytes towards the pins and bytes from the pins
    // ************************************************************
    afb_fifo #(.W(afb_pkg::DW), .D(afb_pkg::FIFO_DEPTH)) u_rx (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (rx_push),
        .in_ready  (rx_ready),
        .in_data   (avs_writedata[7:0]),
        .out_valid (rx_valid),
        .out_ready (rx_pop),
        .out_data  (rx_head),
        .count     (rx_cnt)
    );

    afb_fifo #(.W(afb_pkg::DW), .D(afb_pkg::FIFO_DEPTH)) u_tx (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (tx_push),
        .in_ready  (tx_ready),
        .in_data   (pin_i.data),
        .out_valid (tx_valid),
        .out_ready (tx_pop),
        .out_data  (tx_head),
        .count     (tx_cnt)
    );

    // Mode comes only from the stored port-mode setting
    assign mode      = afb_pkg::afb_mode_t'(s_reg.ctrl[1:0]); // R11
    assign rd_fall   = s_reg.rd_n_q & ~pin_i.rd_n;
    assign rd_rise   = ~s_reg.rd_n_q & pin_i.rd_n;
    assign wr_fall   = s_reg.wr_n_q & ~pin_i.wr_n;
    assign wake_fall = s_reg.wake_n_q & ~pin_i.wake_n;
    assign req       = avs_read | avs_write;
    assign commit    = req & ~s_reg.waitreq;
    // Full receive buffer holds the bus write off: real back-pressure
    assign stall     = avs_write & (avs_address == afb_pkg::REG_RX_PUSH)
                       & ~rx_ready;

    // ************************************************************
    // Read data
    // ************************************************************
    always_comb begin
        unique case (avs_address)
            afb_pkg::REG_CTRL:   rd_mux = {24'h000000, s_reg.ctrl};
            afb_pkg::REG_STAT:   rd_mux = {11'h000, tx_cnt, 3'h0, rx_cnt,
                                           4'h0, ~s_reg.pin.tx_space_n,
                                           ~s_reg.pin.rx_avail_n,
                                           s_reg.flush_req,
                                           s_reg.resume_req};
            afb_pkg::REG_TX_POP: rd_mux = {23'h000000, tx_valid, tx_head};
            afb_pkg::REG_BB_DIR: rd_mux = {24'h000000, s_reg.bb_dir};
            afb_pkg::REG_BB_IN:  rd_mux = (mode == afb_pkg::MODE_BB_ASYNC)
                                          ? {24'h000000, pin_i.data}
                                          : {24'h000000, s_reg.bb_in};
            default:             rd_mux = 32'h00000000;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_next   = s_reg;
        rx_push  = 1'b0;
        rx_pop   = 1'b0;
        tx_push  = 1'b0;
        tx_pop   = 1'b0;
        s_next.rd_n_q   = pin_i.rd_n;
        s_next.wr_n_q   = pin_i.wr_n;
        s_next.wake_n_q = pin_i.wake_n;
        // Flags driven from the first cycle out of reset
        s_next.pin.rx_avail_oe = 1'b1; // R8
        s_next.pin.tx_space_oe = 1'b1; // R8
        s_next.pin.power_enable_n = s_reg.ctrl[afb_pkg::CTRL_SUSPEND];
        s_next.pin.pin_write_pulse_n  = 1'b1;
        s_next.pin.pin_sample_pulse_n = 1'b1;

        // Bus: one wait cycle unless stalled, data prepared before the taking edge
        s_next.waitreq = 1'b1;
        if (req && s_reg.waitreq && !stall) begin
            s_next.waitreq = 1'b0;
            s_next.rdata   = rd_mux;
            if (avs_read && avs_address == afb_pkg::REG_BB_IN &&
                mode == afb_pkg::MODE_BB_ASYNC) begin
                s_next.bb_in                  = pin_i.data; // R15
                s_next.pin.pin_sample_pulse_n = 1'b0;       // R15
            end
        end
        if (commit && avs_write && avs_byteenable[0]) begin
            unique case (avs_address)
                afb_pkg::REG_CTRL: begin
                    s_next.ctrl = avs_writedata[7:0];
                end
                afb_pkg::REG_STAT: begin
                    if (avs_writedata[afb_pkg::ST_RESUME]) begin
                        s_next.resume_req = 1'b0;
                    end
                    if (avs_writedata[afb_pkg::ST_FLUSH]) begin
                        s_next.flush_req = 1'b0;
                    end
                end
                afb_pkg::REG_RX_PUSH: begin
                    rx_push = 1'b1;
                end
                afb_pkg::REG_BB_OUT: begin
                    s_next.bb_out = avs_writedata[7:0];
                    if (mode == afb_pkg::MODE_BB_SYNC) begin
                        // Sync variant samples before the new value lands
                        s_next.bb_in                  = pin_i.data; // R15
                        s_next.pin.pin_sample_pulse_n = 1'b0;       // R15
                    end
                    if (mode == afb_pkg::MODE_BB_SYNC ||
                        mode == afb_pkg::MODE_BB_ASYNC) begin
                        s_next.pin.pin_write_pulse_n = 1'b0; // R14
                    end
                end
                afb_pkg::REG_BB_DIR: begin
                    s_next.bb_dir = avs_writedata[7:0];
                end
                default: begin
                end
            endcase
        end
        if (commit && avs_read && avs_address == afb_pkg::REG_TX_POP) begin
            tx_pop = tx_valid;
        end

        // Wake strobe events after the clear, so a set is never lost
        if (wake_fall) begin
            if (s_reg.pin.power_enable_n &&
                s_reg.ctrl[afb_pkg::CTRL_WAKE_EN]) begin
                s_next.resume_req = 1'b1; // R9
            end else if (!s_reg.pin.power_enable_n) begin
                s_next.flush_req = 1'b1; // R10
            end
        end

        // Pin behaviour per mode
        unique case (mode)
            afb_pkg::MODE_FIFO: begin
                s_next.pin.data_oe = {8{~pin_i.rd_n}}; // R1
                if (rd_fall) begin
                    s_next.pin.data = rx_head; // R5
                end
                if (rd_rise) begin
                    rx_pop = rx_valid; // R6
                end
                if (wr_fall) begin
                    tx_push = tx_ready; // R7
                end
            end
            afb_pkg::MODE_BB_ASYNC,
            afb_pkg::MODE_BB_SYNC: begin
                // Same pins and strobes in both variants
                s_next.pin.data    = s_next.bb_out;  // R12 R13
                s_next.pin.data_oe = s_next.bb_dir;  // R12
            end
            afb_pkg::MODE_OFF: begin
                s_next.pin.data_oe = 8'h00;
            end
        endcase

        // Flags follow next-cycle counts so they never lag a transfer
        rx_cnt_next = rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
        tx_cnt_next = tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
        s_next.pin.rx_avail_n = (mode != afb_pkg::MODE_FIFO) | rd_rise
                                | (rx_cnt_next == afb_pkg::CNT_ZERO); // R2 R3
        s_next.pin.tx_space_n = (mode != afb_pkg::MODE_FIFO)
                                | (tx_cnt_next == afb_pkg::CNT_FULL); // R4 R16
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_reg <= ST_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign avs_readdata    = s_reg.rdata;
    assign avs_waitrequest = s_reg.waitreq;
    assign pin_o           = s_reg.pin;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence bb_out_taken;
        (mode == afb_pkg::MODE_BB_SYNC || mode == afb_pkg::MODE_BB_ASYNC)
        && commit && avs_write && avs_byteenable[0]
        && avs_address == afb_pkg::REG_BB_OUT;
    endsequence

    sequence strobe_pulse;
        !pin_o.pin_write_pulse_n ##1 pin_o.pin_write_pulse_n;
    endsequence

    sequence fifo_rd_rise;
        mode == afb_pkg::MODE_FIFO && rd_rise;
    endsequence

    chk_bus_drive_rd: assert property ( // R1
        mode == afb_pkg::MODE_FIFO |=>
            pin_o.data_oe == {8{~$past(pin_i.rd_n)}})
        else $error("data bus drive does not follow read strobe");

    chk_rd_fall_data: assert property ( // R5
        mode == afb_pkg::MODE_FIFO && rd_fall |=>
            pin_o.data == $past(rx_head))
        else $error("receive byte not placed on read strobe fall");

    chk_rx_flag_high: assert property ( // R3
        fifo_rd_rise |=> pin_o.rx_avail_n)
        else $error("receive flag not forced high after read");

    chk_rx_flag_low: assert property ( // R2
        mode == afb_pkg::MODE_FIFO && pin_i.rd_n && s_reg.rd_n_q
        && rx_valid && !rx_pop ##1 mode == afb_pkg::MODE_FIFO
        |-> !pin_o.rx_avail_n)
        else $error("receive flag high with byte waiting");

    chk_rx_advance: assert property ( // R6
        fifo_rd_rise and rx_valid && !rx_push |=>
            rx_cnt == $past(rx_cnt) - 5'h01)
        else $error("receive buffer did not advance");

    chk_tx_capture: assert property ( // R7
        mode == afb_pkg::MODE_FIFO && wr_fall && tx_ready && !tx_pop
        |=> tx_cnt == $past(tx_cnt) + 5'h01)
        else $error("write strobe byte not captured");

    chk_tx_full_flag: assert property ( // R16
        tx_cnt == afb_pkg::CNT_FULL |-> pin_o.tx_space_n)
        else $error("transmit flag low while buffer full");

    chk_flags_reset: assert property ( // R8
        @(posedge clk_sys) disable iff (1'b0)
        rst |=> !pin_o.rx_avail_oe && !pin_o.tx_space_oe)
        else $error("flag driven during reset");

    chk_wake_resume: assert property ( // R9
        wake_fall && pin_o.power_enable_n
        && s_reg.ctrl[afb_pkg::CTRL_WAKE_EN] |=> s_reg.resume_req)
        else $error("resume request not raised");

    chk_wake_flush: assert property ( // R10
        wake_fall && !pin_o.power_enable_n |=> s_reg.flush_req)
        else $error("flush request not raised");

    chk_bb_strobe: assert property ( // R14
        bb_out_taken |=> strobe_pulse)
        else $error("bit-bang write strobe missing");

    chk_sample_rise: assert property ( // R15
        !pin_o.pin_sample_pulse_n |=> pin_o.pin_sample_pulse_n)
        else $error("sample strobe did not rise");

    chk_bus_answer: assert property (
        req && avs_waitrequest && !stall |=> !avs_waitrequest)
        else $error("bus answer late");

endmodule // afb_port

// >>> tb/afb_partner.sv
// Purpose: External controller model on the parallel FIFO pins.
// Assumes: Flags arrive already resolved with their pull-ups.
// Notes:   Released data lines show the inverse of the last write_byte byte; set_bus drives its byte as is.
`timescale 1ns/1ps

module afb_partner (
    // Clock
    input  logic       clk_sys,
    // From the device
    input  logic [7:0] bus,
    input  logic       rx_avail_n,
    input  logic       tx_space_n,
    // Toward the device
    output logic [7:0] drv_data,
    output logic       rd_n,
    output logic       wr_n,
    output logic       wake_n
);
    // Strobes idle high through reset
    initial begin
        drv_data = 8'h00;
        rd_n     = 1'b1;
        wr_n     = 1'b1;
        wake_n   = 1'b1;
    end

    task automatic read_byte(output logic [7:0] b);
        int n = 0;
        while (rx_avail_n !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        rd_n <= 1'b0;
        @(posedge clk_sys);
        @(posedge clk_sys);
        b = bus;
        rd_n <= 1'b1;
    endtask

    // Ign set: write regardless of the flag, to be refused
    task automatic write_byte(input logic [7:0] b, input bit ign);
        int n = 0;
        while (!ign && tx_space_n !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        drv_data <= b;
        wr_n     <= 1'b0;
        @(posedge clk_sys);
        wr_n     <= 1'b1;
        drv_data <= ~b;
    endtask

    task automatic wake_pulse();
        @(posedge clk_sys);
        wake_n <= 1'b0;
        @(posedge clk_sys);
        wake_n <= 1'b1;
    endtask

    task automatic set_bus(input logic [7:0] b);
        @(posedge clk_sys);
        drv_data <= b;
    endtask
endmodule // afb_partner

// >>> tb/afb_port_tb.sv
// Purpose: Self-checking bench for the parallel FIFO / bit-bang port.
// Assumes: Partner model drives the pins; bench plays the USB side.
// Notes:   Reads are noted in a queue and judged by a monitor.
`timescale 1ns/1ps
`define AFB_CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("ERROR %s exp %0h got %0h", nm, exp, got); \
        end \
    end

module afb_port_tb;
    logic                  clk_sys = 1'b0;
    logic                  rst = 1'b1;
    logic [4:0]            avs_address = 5'h00;
    logic                  avs_read = 1'b0;
    logic                  avs_write = 1'b0;
    logic [31:0]           avs_writedata = 32'h0;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    afb_pkg::afb_pin_in_t  pin_i;
    afb_pkg::afb_pin_out_t pin_o;
    logic [7:0]            bus, p_data;
    logic                  p_rd_n, p_wr_n, p_wake_n, rxf, txe;
    logic [31:0]           exp_q [$];
    logic [7:0]            byte_q [$];
    logic [31:0]           res, ex;
    event                  res_ev;
    int                    errors = 0;
    int                    checks = 0;
    int                    wr_pulses = 0;
    int                    rd_pulses = 0;

    // ************************************************************
    // Wires, pull-ups and instances
    // ************************************************************
    assign bus = (pin_o.data_oe & pin_o.data) | (~pin_o.data_oe & p_data);
    assign rxf = pin_o.rx_avail_oe ? pin_o.rx_avail_n : 1'b1;
    assign txe = pin_o.tx_space_oe ? pin_o.tx_space_n : 1'b1;
    assign pin_i = {bus, p_rd_n, p_wr_n, p_wake_n};

    always #5 clk_sys = ~clk_sys;

    afb_port afb_port_inst (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_i(pin_i), .pin_o(pin_o));

    afb_partner afb_partner_inst (.clk_sys(clk_sys), .bus(bus),
        .rx_avail_n(rxf), .tx_space_n(txe), .drv_data(p_data),
        .rd_n(p_rd_n), .wr_n(p_wr_n), .wake_n(p_wake_n));

    always @(posedge clk_sys) begin
        if (pin_o.pin_write_pulse_n === 1'b0) wr_pulses++;
        if (pin_o.pin_sample_pulse_n === 1'b0) rd_pulses++;
    end

    always begin
        @(res_ev);
        ex = exp_q.pop_front();
        `AFB_CHK("result", ex, res)
    end

    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic av(input logic [4:0] a, input bit w,
                      input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 500);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 500) errors++;
    endtask

    task automatic av_w(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        av(a, 1'b0, 32'h0, res);
        -> res_ev;
    endtask

    task automatic settle();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Run needs a few hundred cycles; 20000 leaves ample margin
    initial begin
        #200000;
        errors++;
        end_sim();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic [7:0]  b;
        logic [31:0] ctl [3];
        logic [31:0] st [3];
        int          i, n;
        ctl = '{32'h8, 32'hC, 32'h0};
        st  = '{32'h8, 32'h9, 32'hA};
        void'($urandom(32'h67F4));
        // Sixth edge samples reset high, release lands on the seventh
        repeat (5) @(posedge clk_sys);
        #1;
        `AFB_CHK("rst_oe", 2'b00, {pin_o.rx_avail_oe, pin_o.tx_space_oe})
        `AFB_CHK("rst_flags", 2'b11, {rxf, txe})
        @(posedge clk_sys) rst <= 1'b0;
        settle();
        `AFB_CHK("idle_flags", 2'b10, {rxf, txe})
        $display("test reset done");
        // Receive path filled to depth, then drained in order
        for (i = 0; i < 16; i++) begin
            b = 8'($urandom);
            byte_q.push_back(b);
            av_w(afb_pkg::REG_RX_PUSH, {24'h0, b});
        end
        rd_chk(afb_pkg::REG_STAT, 32'h0000100C);
        for (i = 0; i < 16; i++) begin
            exp_q.push_back({24'h0, byte_q.pop_front()});
            afb_partner_inst.read_byte(b);
            res = {24'h0, b};
            -> res_ev;
            settle();
            `AFB_CHK("rx_release", 9'h100, {rxf, pin_o.data_oe})
        end
        settle();
        `AFB_CHK("rx_empty", 1'b1, rxf)
        $display("test rx done");
        // Transmit path: one write too many must be dropped
        for (i = 0; i < 17; i++) begin
            b = 8'($urandom);
            afb_partner_inst.write_byte(b, i == 16);
            if (i < 16) byte_q.push_back(b);
            if (i == 15) begin
                // Flag launched by the capture edge, look once it stands
                settle();
                `AFB_CHK("tx_full", 1'b1, txe)
            end
        end
        for (i = 0; i < 16; i++) begin
            b = byte_q.pop_front();
            rd_chk(afb_pkg::REG_TX_POP, {23'h0, 1'b1, b});
            settle();
            `AFB_CHK("tx_space", 1'b0, txe)
        end
        rd_chk(afb_pkg::REG_STAT, 32'h00000008);
        $display("test tx done");
        // Wake strobe: ignored, resume, flush
        for (i = 0; i < 3; i++) begin
            av_w(afb_pkg::REG_CTRL, ctl[i]);
            av_w(afb_pkg::REG_STAT, 32'h3);
            afb_partner_inst.wake_pulse();
            rd_chk(afb_pkg::REG_STAT, st[i]);
            `AFB_CHK("pwr_en", ctl[i][3], pin_o.power_enable_n)
        end
        $display("test wake done");
        // Both bit-bang variants
        for (i = 1; i < 3; i++) begin
            av_w(afb_pkg::REG_CTRL, 32'(i));
            settle();
            `AFB_CHK("bb_flags", 2'b11, {rxf, txe})
            av_w(afb_pkg::REG_BB_DIR, 32'hFF);
            b = 8'($urandom);
            n = wr_pulses;
            av_w(afb_pkg::REG_BB_OUT, {24'h0, b});
            settle();
            `AFB_CHK("bb_oe", 8'hFF, pin_o.data_oe)
            `AFB_CHK("bb_out", b, bus)
            `AFB_CHK("bb_wr", n + 1, wr_pulses)
            av_w(afb_pkg::REG_BB_DIR, 32'h0);
            b = 8'($urandom);
            afb_partner_inst.set_bus(b);
            n = rd_pulses;
            av_w(afb_pkg::REG_BB_OUT, 32'h0);
            rd_chk(afb_pkg::REG_BB_IN, {24'h0, b});
            settle();
            `AFB_CHK("bb_sample", n + 1, rd_pulses)
        end
        // Off mode must release the lines even with all enables set
        av_w(afb_pkg::REG_BB_DIR, 32'hFF);
        av_w(afb_pkg::REG_CTRL, 32'h3);
        settle();
        `AFB_CHK("off_pins", 10'h003, {pin_o.data_oe, rxf, txe})
        rd_chk(5'h1C, 32'h0);
        $display("test bitbang done");
        settle();
        end_sim();
    end
endmodule // afb_port_tb
